/* epc_pkg.sv */
// Purpose: Constants, types and register layout of the program control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register indexes are kept; byte address is four times the index
`default_nettype none
package epc_pkg;
   // Register indexes and array windows
   localparam logic [13:0] EPC_CTL_IDX = 14'h0007;
   localparam logic [13:0] EPC_OPT_IDX = 14'h0100;
   localparam logic [13:0] EPC_NVM_BASE_IDX = 14'h0100;
   localparam logic [13:0] EPC_OTP_BASE_IDX = 14'h0400;
   localparam int EPC_NVM_BYTES = 256;
   localparam int EPC_OTP_BYTES = 64;
   localparam int EPC_OTP_GROUP = 16;
   // Lowest nonvolatile bytes that can never be protected
   localparam logic [7:0] EPC_NVM_OPEN_BYTES = 8'h20;
   // Reset values and special data
   localparam logic [7:0] EPC_CTL_RESET = 8'h00;
   localparam logic [7:0] EPC_OTP_BLANK = 8'h00;
   localparam logic [7:0] EPC_OTP_LATCHED_RD = 8'hff;
   localparam logic [7:0] EPC_NVM_ERASED = 8'hff;
   // Options byte field positions
   localparam int EPC_OPT_SEC_BIT = 0;
   localparam int EPC_OPT_PROT_BIT = 1;

   // Control register layout, bit 7 first
   typedef struct packed {
      logic wired_or_irq_enable;
      logic can_asleep_flag;
      logic otp_latch_enable;
      logic otp_program_enable;
      logic clock_output_enable;
      logic nvm_erase_select;
      logic nvm_latch_enable;
      logic nvm_charge_pump_enable;
   } epc_ctl_t;

   typedef enum logic [1:0] {
      EPC_RG_NONE = 2'b00,
      EPC_RG_CTL = 2'b01,
      EPC_RG_NVM = 2'b10,
      EPC_RG_OTP = 2'b11
   } epc_region_t;

   // Nonvolatile control triple: erase select, latch, pump
   typedef enum logic [2:0] {
      EPC_NVM_READ = 3'b000,
      EPC_NVM_LOAD_PGM = 3'b010,
      EPC_NVM_PGM = 3'b011,
      EPC_NVM_LOAD_ERA = 3'b110,
      EPC_NVM_ERA = 3'b111
   } epc_nvm_state_t;
endpackage
`default_nettype wire

/* epc_program_control.sv */
// Purpose: One-time and nonvolatile memory program control with APB access
// Assumes: CPU-clock inputs (stop, CAN events, straps) are synchronous to pclk
// Notes: Zero wait states; read data is captured in the setup cycle
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module epc_program_control
   import epc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_mode,
   input wire logic wired_or_mask_option,
   input wire logic bootstrap_mode,
   input wire logic can_sleep_enter,
   input wire logic can_wake,
   output logic wired_or_irq_active,
   output logic otp_fetch_inhibit,
   output logic otp_program_active,
   output logic nvm_high_voltage,
   output logic clock_output_enable,
   output logic non_user_mode_allowed,
   output epc_nvm_state_t nvm_state
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding
   // Decode used by both the read capture and the write paths
   function automatic epc_region_t epc_decode(input logic [15:0] a);
      logic [13:0] idx;
      idx = a[15:2];
      if (a[1:0] != 2'b00)
         epc_decode = EPC_RG_NONE;
      else if (idx == EPC_CTL_IDX)
         epc_decode = EPC_RG_CTL;
      else if (idx[13:8] == EPC_NVM_BASE_IDX[13:8])
         epc_decode = EPC_RG_NVM;
      else if (idx[13:6] == EPC_OTP_BASE_IDX[13:6])
         epc_decode = EPC_RG_OTP;
      else
         epc_decode = EPC_RG_NONE;
   endfunction

   epc_ctl_t ctl_r;
   epc_ctl_t ctl_nxt;
   epc_region_t region;
   logic wr_ev;
   logic rd_setup;
   logic [7:0] nvm_idx;
   logic [5:0] otp_idx;
   logic [7:0] otp_mem_r [0:EPC_OTP_BYTES-1];
   logic [7:0] nvm_mem_r [0:EPC_NVM_BYTES-1];
   logic [7:0] otp_buf_r [0:EPC_OTP_GROUP-1];
   logic [15:0] otp_mask_r;
   logic [1:0] otp_grp_r;
   logic [7:0] nvm_addr_r;
   logic [7:0] nvm_data_r;
   logic nvm_loaded_r;
   logic otp_pgm_ev;
   logic nvm_pump_ev;
   logic otp_capture;
   logic nvm_capture;
   logic sampled_r;
   logic unprot_r;
   logic sec_open_r;
   logic nvm_protected;
   logic [7:0] rd_byte;
   logic [31:0] prdata_r;
   logic pslverr_r;

   assign region = epc_decode(paddr);
   assign wr_ev = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign nvm_idx = paddr[9:2];
   assign otp_idx = paddr[7:2];

   ////////////////////////////////////////////////////////////////////////////
   // Control register next value
   // Clears are applied last so a dropped latch always wins over a set
   always_comb
   begin
      ctl_nxt = ctl_r;
      if (wr_ev && region == EPC_RG_CTL)
      begin
         ctl_nxt.wired_or_irq_enable = pwdata[7];
         ctl_nxt.otp_latch_enable = pwdata[5];
         ctl_nxt.clock_output_enable = pwdata[3];
         ctl_nxt.nvm_latch_enable = pwdata[1];
         // Enable accepted only with data already captured; zero writes ignored
         if (pwdata[4] && pwdata[5] && ctl_r.otp_latch_enable && otp_mask_r != 16'h0000)
            ctl_nxt.otp_program_enable = 1'b1;
         // Erase select frozen once the target address is latched
         if (!nvm_loaded_r)
            ctl_nxt.nvm_erase_select = pwdata[2];
         // Pump refused until data latched; zero writes ignored, only dropping the latch clears it
         if (pwdata[0] && pwdata[1] && ctl_r.nvm_latch_enable && nvm_loaded_r)
            ctl_nxt.nvm_charge_pump_enable = 1'b1;
      end
      // Wake clears, sleep entry sets; entry wins when both arrive together
      if (can_wake)
         ctl_nxt.can_asleep_flag = 1'b0;
      if (can_sleep_enter)
         ctl_nxt.can_asleep_flag = 1'b1;
      if (stop_mode)
      begin
         ctl_nxt.otp_latch_enable = 1'b0;
         ctl_nxt.nvm_latch_enable = 1'b0;
      end
      if (!ctl_nxt.otp_latch_enable)
         ctl_nxt.otp_program_enable = 1'b0;
      if (!ctl_nxt.nvm_latch_enable)
      begin
         ctl_nxt.nvm_erase_select = 1'b0;
         ctl_nxt.nvm_charge_pump_enable = 1'b0;
      end
   end

   // Reset clears the whole register, wired-OR enable included
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_r <= EPC_CTL_RESET;
      else
         ctl_r <= ctl_nxt;
   end

   assign otp_pgm_ev = ctl_nxt.otp_program_enable & ~ctl_r.otp_program_enable;
   assign nvm_pump_ev = ctl_nxt.nvm_charge_pump_enable & ~ctl_r.nvm_charge_pump_enable;

   ////////////////////////////////////////////////////////////////////////////
   // One-time memory capture and programming
   // A byte outside the first byte's group is dropped, so a group never mixes
   assign otp_capture = wr_ev && region == EPC_RG_OTP && ctl_r.otp_latch_enable
      && !ctl_r.otp_program_enable
      && (otp_mask_r == 16'h0000 || otp_grp_r == otp_idx[5:4]);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         otp_mask_r <= 16'h0000;
         otp_grp_r <= 2'b00;
      end
      else if (!ctl_nxt.otp_latch_enable)
         otp_mask_r <= 16'h0000;
      else if (otp_capture)
      begin
         otp_mask_r[otp_idx[3:0]] <= 1'b1;
         otp_grp_r <= otp_idx[5:4];
      end
   end

   // Data buffer needs no reset; the mask says which entries are valid
   always_ff @(posedge pclk)
   begin
      if (otp_capture)
         otp_buf_r[otp_idx[3:0]] <= pwdata[7:0];
   end

   // Array model: presetn stands for power-on, so the array starts blank
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < EPC_OTP_BYTES; i++)
            otp_mem_r[i] <= EPC_OTP_BLANK;
      end
      else if (otp_pgm_ev)
      begin
         for (int j = 0; j < EPC_OTP_GROUP; j++)
            if (otp_mask_r[j])
               otp_mem_r[{otp_grp_r, j[3:0]}] <= otp_mem_r[{otp_grp_r, j[3:0]}]
                  | otp_buf_r[j];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Nonvolatile memory capture and program or erase
   // Protection lapses in bootstrap mode or once the protect bit was seen set
   assign nvm_protected = ~unprot_r & ~bootstrap_mode;
   assign nvm_capture = wr_ev && region == EPC_RG_NVM && ctl_r.nvm_latch_enable
      && !ctl_r.nvm_charge_pump_enable;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nvm_loaded_r <= 1'b0;
         nvm_addr_r <= 8'h00;
         nvm_data_r <= 8'h00;
      end
      else if (!ctl_nxt.nvm_latch_enable)
         nvm_loaded_r <= 1'b0;
      else if (nvm_capture)
      begin
         nvm_loaded_r <= 1'b1;
         nvm_addr_r <= nvm_idx;
         nvm_data_r <= pwdata[7:0];
      end
   end

   // No reset: the array holds the options byte, which must outlive resets
   always_ff @(posedge pclk)
   begin
      if (nvm_pump_ev && !(nvm_protected && nvm_addr_r >= EPC_NVM_OPEN_BYTES))
      begin
         if (ctl_r.nvm_erase_select)
            nvm_mem_r[nvm_addr_r] <= EPC_NVM_ERASED;
         else
            nvm_mem_r[nvm_addr_r] <= nvm_mem_r[nvm_addr_r] & nvm_data_r;
      end
   end

   // Triple shown as a state; codes outside the table cannot arise
   always_comb
   begin
      unique case ({ctl_r.nvm_erase_select, ctl_r.nvm_latch_enable,
                    ctl_r.nvm_charge_pump_enable})
         3'b000: nvm_state = EPC_NVM_READ;
         3'b010: nvm_state = EPC_NVM_LOAD_PGM;
         3'b011: nvm_state = EPC_NVM_PGM;
         3'b110: nvm_state = EPC_NVM_LOAD_ERA;
         3'b111: nvm_state = EPC_NVM_ERA;
         default: nvm_state = EPC_NVM_READ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Option effects sampled after reset release
   // Options bits are read from the array, only their effect is held here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sampled_r <= 1'b0;
         unprot_r <= 1'b0;
         sec_open_r <= 1'b0;
      end
      else
      begin
         sampled_r <= 1'b1;
         if (!sampled_r)
            sec_open_r <= nvm_mem_r[EPC_OPT_IDX[7:0]][EPC_OPT_SEC_BIT];
         // Once unprotected, stays so until the next reset
         if (nvm_mem_r[EPC_OPT_IDX[7:0]][EPC_OPT_PROT_BIT] == 1'b1)
            unprot_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read path and outputs
   // Read byte selection for the addressed location
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (region)
         EPC_RG_CTL:
         begin
            rd_byte = ctl_r;
            rd_byte[7] = ctl_r.wired_or_irq_enable & wired_or_mask_option;
         end
         EPC_RG_NVM: rd_byte = nvm_mem_r[nvm_idx];
         EPC_RG_OTP: rd_byte = ctl_r.otp_latch_enable ? EPC_OTP_LATCHED_RD
            : otp_mem_r[otp_idx];
         EPC_RG_NONE: rd_byte = 8'h00;
      endcase
   end

   // Captured in setup so the data output comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else if (rd_setup)
      begin
         prdata_r <= {24'h000000, rd_byte};
         pslverr_r <= (region == EPC_RG_NONE);
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r;
   assign wired_or_irq_active = ctl_r.wired_or_irq_enable & wired_or_mask_option;
   assign otp_fetch_inhibit = ctl_r.otp_latch_enable;
   assign otp_program_active = ctl_r.otp_program_enable;
   assign nvm_high_voltage = ctl_r.nvm_charge_pump_enable;
   assign clock_output_enable = ctl_r.clock_output_enable;
   assign non_user_mode_allowed = sec_open_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_otp_read_masked;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && region == EPC_RG_OTP && ctl_r.otp_latch_enable)
         |=> (prdata[7:0] == EPC_OTP_LATCHED_RD);
   endproperty
   a_otp_read_masked: assert property (p_otp_read_masked)
      else $error("latched one-time read did not return filler");

   property p_stop_clears;
      @(posedge pclk) disable iff (!presetn)
      stop_mode |=> (!ctl_r.otp_latch_enable && !ctl_r.otp_program_enable
         && !ctl_r.nvm_latch_enable && !ctl_r.nvm_charge_pump_enable);
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("stop left a latch set");

   property p_pgm_needs_latch;
      @(posedge pclk) disable iff (!presetn)
      $rose(ctl_r.otp_program_enable) |-> ($past(ctl_r.otp_latch_enable)
         && $past(otp_mask_r) != 16'h0000);
   endproperty
   a_pgm_needs_latch: assert property (p_pgm_needs_latch)
      else $error("program enable set without latch and data");

   property p_otp_accumulate;
      @(posedge pclk) disable iff (!presetn)
      ((otp_mem_r[0] & $past(otp_mem_r[0])) == $past(otp_mem_r[0]));
   endproperty
   a_otp_accumulate: assert property (p_otp_accumulate)
      else $error("one-time bit returned to zero");

   property p_wired_or_irq_enable_forced;
      @(posedge pclk) disable iff (!presetn)
      !wired_or_mask_option |-> !wired_or_irq_active;
   endproperty
   a_wired_or_irq_enable_forced: assert property (p_wired_or_irq_enable_forced)
      else $error("wired-OR enable active without mask option");

   property p_can_flag;
      @(posedge pclk) disable iff (!presetn)
      (can_sleep_enter |=> ctl_r.can_asleep_flag)
         and ((can_wake && !can_sleep_enter) |=> !ctl_r.can_asleep_flag);
   endproperty
   a_can_flag: assert property (p_can_flag)
      else $error("asleep flag did not follow CAN events");

   property p_pump_needs_data;
      @(posedge pclk) disable iff (!presetn)
      $rose(ctl_r.nvm_charge_pump_enable) |-> $past(nvm_loaded_r);
   endproperty
   a_pump_needs_data: assert property (p_pump_needs_data)
      else $error("pump switched on before data latched");

   property p_era_frozen;
      @(posedge pclk) disable iff (!presetn)
      (nvm_loaded_r && $past(nvm_loaded_r)) |-> $stable(ctl_r.nvm_erase_select);
   endproperty
   a_era_frozen: assert property (p_era_frozen)
      else $error("erase select changed after address latched");

   property p_latch_clear;
      @(posedge pclk) disable iff (!presetn)
      !ctl_r.nvm_latch_enable |-> (!ctl_r.nvm_erase_select
         && !ctl_r.nvm_charge_pump_enable && !nvm_loaded_r);
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("erase select or pump set without latch");

endmodule
`default_nettype wire

/* tb_epc_program_control.sv */
// Purpose: Self-checking bench for the program control block over APB
// Assumes: Zero-wait slave; the bench drives every strap and event input
// Notes: Nonvolatile bytes start unknown, so each one is erased before use
`timescale 1ns/10ps
`default_nettype none
module tb_epc_program_control
   import epc_pkg::*;
;
   localparam logic [15:0] A_CTL = {EPC_CTL_IDX, 2'b00};
   localparam logic [15:0] A_OPT = {EPC_OPT_IDX, 2'b00};
   localparam logic [15:0] A_UP = A_OPT + 16'h0080;
   localparam logic [15:0] A_OTP = {EPC_OTP_BASE_IDX, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic stop_mode = 1'b0;
   logic wired_or_mask_option = 1'b0;
   logic bootstrap_mode = 1'b0;
   logic can_sleep_enter = 1'b0;
   logic can_wake = 1'b0;
   logic wired_or_irq_active;
   logic otp_fetch_inhibit;
   logic otp_program_active;
   logic nvm_high_voltage;
   logic clock_output_enable;
   logic non_user_mode_allowed;
   epc_nvm_state_t nvm_state;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;

   epc_program_control i_epc_program_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .wired_or_mask_option(wired_or_mask_option),
      .bootstrap_mode(bootstrap_mode), .can_sleep_enter(can_sleep_enter), .can_wake(can_wake),
      .wired_or_irq_active(wired_or_irq_active), .otp_fetch_inhibit(otp_fetch_inhibit),
      .otp_program_active(otp_program_active), .nvm_high_voltage(nvm_high_voltage),
      .clock_output_enable(clock_output_enable), .non_user_mode_allowed(non_user_mode_allowed),
      .nvm_state(nvm_state)
   );

   // 20 MHz clock
   always #25 pclk = ~pclk;

   // Hang guard, well above the roughly one hundred APB transfers of the run
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         n_errors = n_errors + 1;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Request held until pready is seen high; #1 lets the write edge settle
   task automatic apb(input logic wr_en, input logic [15:0] addr, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= addr;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [15:0] addr, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, addr, d, rd, err);
   endtask

   task automatic rd_chk(input string name, input logic [15:0] addr, input logic [7:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, addr, 8'h00, rd, err);
      check(name, {24'h000000, exp}, rd);
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   // Full nonvolatile cycle: load, pump on, back to read
   task automatic nvm_op(input logic [15:0] addr, input logic era, input logic [7:0] d);
      wr(A_CTL, {5'b00000, era, 2'b10});
      wr(addr, d);
      wr(A_CTL, {5'b00000, era, 2'b11});
      check("nvm_state busy", {29'h0, era, 2'b11}, nvm_state);
      check("nvm_high_voltage", 32'h1, nvm_high_voltage);
      wr(A_CTL, 8'h00);
      check("nvm_state idle", EPC_NVM_READ, nvm_state);
   endtask

   // Program enable is set before any supply switching would follow
   task automatic otp_prog(input logic [15:0] addr, input logic [7:0] d);
      wr(A_CTL, 8'h20);
      wr(addr, d);
      wr(A_CTL, 8'h30);
      wr(A_CTL, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_basics();
      logic [31:0] rd;
      logic err;
      rd_chk("ctl reset", A_CTL, EPC_CTL_RESET);
      apb(1'b1, 16'h0020, 8'hff, rd, err);
      check("unmapped err", 32'h1, err);
      apb(1'b0, 16'h001d, 8'h00, rd, err);
      check("misaligned err", 32'h1, err);
      wr(A_CTL, 8'h88);
      rd_chk("ctl no mask", A_CTL, 8'h08);
      check("irq active off", 32'h0, wired_or_irq_active);
      check("clock out", 32'h1, clock_output_enable);
      @(posedge pclk);
      wired_or_mask_option <= 1'b1;
      wr(A_CTL, 8'h80);
      rd_chk("ctl mask", A_CTL, 8'h80);
      check("irq active on", 32'h1, wired_or_irq_active);
      do_reset();
      rd_chk("ctl after reset", A_CTL, 8'h00);
      check("irq after reset", 32'h0, wired_or_irq_active);
   endtask

   // Flag only follows the CAN events, software writes do not touch it
   task automatic t_can();
      @(posedge pclk);
      can_sleep_enter <= 1'b1;
      @(posedge pclk);
      can_sleep_enter <= 1'b0;
      rd_chk("asleep set", A_CTL, 8'h40);
      wr(A_CTL, 8'h00);
      rd_chk("asleep held", A_CTL, 8'h40);
      @(posedge pclk);
      can_wake <= 1'b1;
      @(posedge pclk);
      can_wake <= 1'b0;
      rd_chk("asleep clear", A_CTL, 8'h00);
   endtask

   task automatic t_otp();
      rd_chk("otp blank", A_OTP, EPC_OTP_BLANK);
      wr(A_CTL, 8'h20);
      check("fetch inhibit", 32'h1, otp_fetch_inhibit);
      rd_chk("otp latched read", A_OTP, EPC_OTP_LATCHED_RD);
      wr(A_CTL, 8'h30);
      rd_chk("pgm without data", A_CTL, 8'h20);
      wr(A_OTP, 8'h0f);
      wr(A_OTP + 16'h0004, 8'h30);
      wr(A_OTP + 16'h0040, 8'hc0);
      wr(A_CTL, 8'h30);
      rd_chk("otp programming", A_CTL, 8'h30);
      check("otp active", 32'h1, otp_program_active);
      wr(A_CTL, 8'h20);
      rd_chk("pgm write zero", A_CTL, 8'h30);
      wr(A_CTL, 8'h00);
      rd_chk("latch clear", A_CTL, 8'h00);
      check("fetch inhibit off", 32'h0, otp_fetch_inhibit);
      rd_chk("otp byte0", A_OTP, 8'h0f);
      rd_chk("otp byte1", A_OTP + 16'h0004, 8'h30);
      rd_chk("otp other group", A_OTP + 16'h0040, 8'h00);
      otp_prog(A_OTP, 8'hf0);
      rd_chk("otp accumulate", A_OTP, 8'hff);
      otp_prog(A_OTP + 16'h0004, 8'h00);
      rd_chk("otp ones kept", A_OTP + 16'h0004, 8'h30);
      wr(A_CTL, 8'h22);
      @(posedge pclk);
      stop_mode <= 1'b1;
      @(posedge pclk);
      stop_mode <= 1'b0;
      rd_chk("stop clears", A_CTL, 8'h00);
   endtask

   task automatic t_nvm();
      wr(A_CTL, 8'h02);
      wr(A_CTL, 8'h03);
      rd_chk("pump no data", A_CTL, 8'h02);
      wr(A_CTL, 8'h06);
      wr(A_OPT + 16'h0004, 8'h00);
      wr(A_CTL, 8'h02);
      rd_chk("erase frozen", A_CTL, 8'h06);
      wr(A_CTL, 8'h07);
      wr(A_CTL, 8'h03);
      rd_chk("pump held", A_CTL, 8'h07);
      wr(A_CTL, 8'h00);
      rd_chk("latch clears all", A_CTL, 8'h00);
      rd_chk("erased", A_OPT + 16'h0004, EPC_NVM_ERASED);
      nvm_op(A_OPT + 16'h0004, 1'b0, 8'h5a);
      rd_chk("programmed", A_OPT + 16'h0004, 8'h5a);
      wr(A_CTL, 8'h02);
      wr(A_CTL, 8'h22);
      @(posedge pclk);
      stop_mode <= 1'b1;
      @(posedge pclk);
      stop_mode <= 1'b0;
      rd_chk("stop clears nvm", A_CTL, 8'h00);
   endtask

   task automatic t_protect();
      nvm_op(A_OPT, 1'b1, 8'h00);
      nvm_op(A_UP, 1'b1, 8'h00);
      nvm_op(A_UP, 1'b0, 8'h33);
      rd_chk("upper open", A_UP, 8'h33);
      nvm_op(A_OPT, 1'b0, 8'h00);
      nvm_op(A_UP, 1'b0, 8'h11);
      rd_chk("open until reset", A_UP, 8'h11);
      do_reset();
      rd_chk("options kept", A_OPT, 8'h00);
      check("secured", 32'h0, non_user_mode_allowed);
      nvm_op(A_UP, 1'b1, 8'h00);
      rd_chk("upper protected", A_UP, 8'h11);
      nvm_op(A_UP - 16'h0004, 1'b1, 8'h00);
      rd_chk("last open byte", A_UP - 16'h0004, 8'hff);
      @(posedge pclk);
      bootstrap_mode <= 1'b1;
      nvm_op(A_UP, 1'b1, 8'h00);
      rd_chk("bootstrap open", A_UP, 8'hff);
      @(posedge pclk);
      bootstrap_mode <= 1'b0;
      nvm_op(A_OPT, 1'b1, 8'h00);
      wr(A_OPT, 8'h00);
      rd_chk("options unlatched", A_OPT, 8'hff);
      check("secure before reset", 32'h0, non_user_mode_allowed);
      do_reset();
      check("secure after reset", 32'h1, non_user_mode_allowed);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      do_reset();
      t_basics();
      t_can();
      t_otp();
      t_nvm();
      t_protect();
      end_sim();
   end
endmodule
`default_nettype wire
